// ### uart_cfg_consts.svh
// Constants for the host serial line configuration block
// Overview of operation
// - Setup is one 16-bit value: rate, flags
// - Rate byte 00..0C selects thirteen baud rates
// - Reset value 0500: 19200, 8N1
// - Flag bit 7 enables STX/ETX wrapper
// - Flag bit 5 selects RTS/CTS, else XON/XOFF
// - Hardware mode: RTS out, CTS in on pins
// - Hardware mode blocks pin-control access to those pins
// - Full 128-byte transmit buffer drops new data
// - Flag bit 4 suppresses command echo
// - Flag bit 3 selects seven data bits
// - Flag bit 2 selects two stop bits
// - Flag bit 1 odd parity, checked on receive
// - Flag bit 0 even parity; neither: none
// - Parity never alters forwarded radio payload
`ifndef UART_CFG_CONSTS_SVH
`define UART_CFG_CONSTS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define ADDR_LINE_CONFIG 12'h000
`define ADDR_PIN_CTRL_A 12'h004
`define ADDR_PIN_CTRL_B 12'h008
`define ADDR_STATUS 12'h00c
`define ADDR_TX_DATA 12'h010
`define ADDR_RX_DATA 12'h014

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CFG_RESET 16'h0500
`define CFG_WMASK 16'hffbf
`define BIT_WRAP 7
`define BIT_HWFC 5
`define BIT_NOECHO 4
`define BIT_SEVEN 3
`define BIT_TWOSTOP 2
`define BIT_ODD 1
`define BIT_EVEN 0
`define RATE_MAX 8'h0c
`define PIN_RTS 4
`define PIN_CTS 2
`define TX_DEPTH 128
`define CLK_HZ 100000000
`define CHAR_STX 8'h02
`define CHAR_ETX 8'h03
`define CHAR_XON 8'h11
`define CHAR_XOFF 8'h13

`endif

// ### uart_cfg_pkg.sv
// Types of the host serial line configuration block
package uart_cfg_pkg;
  typedef enum logic [1:0] {
    FC_SOFT = 2'b00,
    FC_HARD = 2'b01
  } flow_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } tx_state_t;
endpackage

// ### baud_gen.sv
// Baud tick divider selected by the rate byte
`timescale 1ns/10ps
`include "uart_cfg_consts.svh"
module baud_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] rate_sel,
  output logic tick
);
  // Slowest rate needs more than 65535 cycles per bit, hence 17 bits
  logic [16:0] count;
  logic [16:0] limit;

  // Last count of a bit period: cycles per bit, rounded down, minus one
  function automatic logic [16:0] div_of(input logic [7:0] sel);
    logic [31:0] baud;
    baud = 32'd19200;
    case (sel)
      8'h00: baud = 32'd1200;
      8'h01: baud = 32'd2400;
      8'h02: baud = 32'd4800;
      8'h03: baud = 32'd9600;
      8'h04: baud = 32'd14400;
      8'h05: baud = 32'd19200;
      8'h06: baud = 32'd28800;
      8'h07: baud = 32'd38400;
      8'h08: baud = 32'd50000;
      8'h09: baud = 32'd57600;
      8'h0a: baud = 32'd76800;
      8'h0b: baud = 32'd100000;
      8'h0c: baud = 32'd115200;
      default: baud = 32'd19200;
    endcase
    div_of = 17'((32'(`CLK_HZ) / baud) - 32'd1);
  endfunction

  assign limit = div_of(rate_sel);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 17'h00000;
      tick <= 1'b0;
    end else if (count >= limit) begin
      count <= 17'h00000;
      tick <= 1'b1;
    end else begin
      count <= count + 17'h00001;
      tick <= 1'b0;
    end
  end
endmodule

// ### host_uart_line_config.sv
// Host serial port: line setup register, APB slave, transmitter and receiver
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
`include "uart_cfg_consts.svh"
module host_uart_line_config #(
  parameter int TX_DEPTH = `TX_DEPTH
) (
  // System
  input wire logic CLK_SYS,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Serial line
  output logic TXD,
  input wire logic RXD,
  // General-purpose pins
  output logic [7:0] GP_OUT,
  output logic [7:0] GP_OE,
  input wire logic [7:0] GP_IN,
  // Radio payload path
  output logic [7:0] RADIO_DATA,
  output logic RADIO_VALID
);
  logic [15:0] uart_line_config;
  logic [7:0] pin_control_reg_a;
  logic [7:0] pin_control_reg_b;
  logic [7:0] txq [0:TX_DEPTH-1];
  logic [7:0] wr_ptr;
  logic [7:0] rd_ptr;
  logic [8:0] fill;
  logic tick;
  logic [3:0] sub;
  uart_cfg_pkg::tx_state_t tx_state;
  logic [7:0] tx_shift;
  logic [2:0] tx_bit;
  logic [1:0] tx_stops;
  logic tx_par;
  logic [7:0] rx_shift;
  logic [3:0] rx_bit;
  logic rx_busy;
  logic [15:0] rx_cnt;
  logic rx_par_err;
  logic [7:0] rx_data;
  logic rx_avail;
  logic drop_seen;
  logic xoff_held;
  logic [7:0] echo_byte;
  logic echo_req;
  logic wr_en;
  logic rd_en;
  logic push;
  logic pop;
  logic [7:0] flags;
  logic hw_fc;
  logic seven;
  logic par_on;
  logic par_odd;
  logic cts_ok;
  logic rx_done;
  logic [7:0] rx_char;
  logic [15:0] half_bit;

  assign flags = uart_line_config[7:0];
  assign hw_fc = flags[`BIT_HWFC];
  assign seven = flags[`BIT_SEVEN];
  assign par_on = flags[`BIT_ODD] | flags[`BIT_EVEN];
  assign par_odd = flags[`BIT_ODD];
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_en = PSEL & PENABLE & ~PWRITE;
  assign cts_ok = hw_fc ? ~GP_IN[`PIN_CTS] : ~xoff_held;

  // Parity over the active data bits
  function automatic logic par_of(input logic [7:0] d, input logic sev, input logic odd);
    logic p;
    p = sev ? ^d[6:0] : ^d;
    par_of = odd ? ~p : p;
  endfunction

  // ----------------------------------------
  // Baud timing
  // ----------------------------------------
  baud_gen u_baud (
    .clk(CLK_SYS),
    .rst(RST),
    .rate_sel(uart_line_config[15:8]),
    .tick(tick)
  );
  assign half_bit = 16'(32'(`CLK_HZ) / 32'd2400);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      uart_line_config <= `CFG_RESET;
    end else if (wr_en && PADDR == `ADDR_LINE_CONFIG) begin
      // Takes effect at once; bit 6 stays zero
      uart_line_config <= PWDATA[15:0] & `CFG_WMASK;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_control_reg_a <= 8'h00;
      pin_control_reg_b <= 8'h00;
    end else if (wr_en) begin
      if (PADDR == `ADDR_PIN_CTRL_A) begin
        pin_control_reg_a <= PWDATA[7:0];
      end
      if (PADDR == `ADDR_PIN_CTRL_B) begin
        pin_control_reg_b <= PWDATA[7:0];
      end
    end
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      GP_OUT <= 8'h00;
      GP_OE <= 8'h00;
    end else begin
      GP_OUT <= pin_control_reg_a;
      GP_OE <= pin_control_reg_b;
      if (hw_fc) begin
        // Pin-control values are masked, not lost, so they return when mode ends
        GP_OUT[`PIN_RTS] <= (fill >= 9'(TX_DEPTH - 8)) | rx_avail;
        GP_OE[`PIN_RTS] <= 1'b1;
        GP_OUT[`PIN_CTS] <= 1'b0;
        GP_OE[`PIN_CTS] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transmit queue
  // ----------------------------------------
  assign push = wr_en && PADDR == `ADDR_TX_DATA && fill < 9'(TX_DEPTH);
  assign pop = tx_state == uart_cfg_pkg::TX_IDLE && !echo_req && fill != 9'h000 && cts_ok;

  always_ff @(posedge CLK_SYS) begin
    if (push) begin
      txq[wr_ptr[6:0]] <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wr_ptr <= 8'h00;
      rd_ptr <= 8'h00;
      fill <= 9'h000;
      drop_seen <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= 8'((wr_ptr + 8'h01) % 8'(TX_DEPTH));
      end
      if (pop) begin
        rd_ptr <= 8'((rd_ptr + 8'h01) % 8'(TX_DEPTH));
      end
      fill <= fill + {8'h00, push} - {8'h00, pop};
      if (wr_en && PADDR == `ADDR_TX_DATA && fill >= 9'(TX_DEPTH)) begin
        drop_seen <= 1'b1;
      end else if (rd_en && PADDR == `ADDR_STATUS) begin
        drop_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tx_state <= uart_cfg_pkg::TX_IDLE;
      TXD <= 1'b1;
      tx_shift <= 8'h00;
      tx_bit <= 3'h0;
      tx_stops <= 2'h0;
      tx_par <= 1'b0;
      echo_req <= 1'b0;
    end else begin
      if (rx_done && !flags[`BIT_NOECHO]) begin
        echo_req <= 1'b1;
      end
      case (tx_state)
        uart_cfg_pkg::TX_IDLE: begin
          if (echo_req) begin
            tx_shift <= echo_byte;
            echo_req <= 1'b0;
            tx_state <= uart_cfg_pkg::TX_START;
          end else if (pop) begin
            tx_shift <= txq[rd_ptr[6:0]];
            tx_state <= uart_cfg_pkg::TX_START;
          end
        end
        uart_cfg_pkg::TX_START: begin
          if (tick) begin
            TXD <= 1'b0;
            tx_bit <= 3'h0;
            tx_par <= par_of(tx_shift, seven, par_odd);
            tx_state <= uart_cfg_pkg::TX_DATA;
          end
        end
        uart_cfg_pkg::TX_DATA: begin
          if (tick) begin
            TXD <= tx_shift[tx_bit];
            tx_bit <= tx_bit + 3'h1;
            if (tx_bit == (seven ? 3'h6 : 3'h7)) begin
              tx_state <= par_on ? uart_cfg_pkg::TX_PAR : uart_cfg_pkg::TX_STOP;
              tx_stops <= flags[`BIT_TWOSTOP] ? 2'h2 : 2'h1;
            end
          end
        end
        uart_cfg_pkg::TX_PAR: begin
          if (tick) begin
            TXD <= tx_par;
            tx_state <= uart_cfg_pkg::TX_STOP;
          end
        end
        uart_cfg_pkg::TX_STOP: begin
          if (tick) begin
            TXD <= 1'b1;
            tx_stops <= tx_stops - 2'h1;
            if (tx_stops == 2'h0) begin
              tx_state <= uart_cfg_pkg::TX_IDLE;
            end
          end
        end
        default: tx_state <= uart_cfg_pkg::TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Receiver, sampled on the free-running tick grid, not realigned to the start bit
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rx_busy <= 1'b0;
      rx_bit <= 4'h0;
      rx_shift <= 8'h00;
      rx_cnt <= 16'h0000;
      rx_done <= 1'b0;
      rx_char <= 8'h00;
      rx_par_err <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (!RXD) begin
          rx_busy <= 1'b1;
          rx_bit <= 4'h0;
          rx_cnt <= 16'h0000;
        end
      end else if (tick) begin
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit >= 4'h1 && rx_bit <= (seven ? 4'h7 : 4'h8)) begin
          rx_shift <= {RXD, rx_shift[7:1]};
        end else if (par_on && rx_bit == (seven ? 4'h8 : 4'h9)) begin
          rx_par_err <= RXD != par_of(seven ? {1'b0, rx_shift[7:1]} : rx_shift, seven,
            par_odd);
        end else if (rx_bit != 4'h0) begin
          rx_busy <= 1'b0;
          rx_done <= 1'b1;
          rx_char <= seven ? {1'b0, rx_shift[7:1]} : rx_shift;
        end
      end
    end
  end

  // ----------------------------------------
  // Receive data, flow control and radio path
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rx_data <= 8'h00;
      rx_avail <= 1'b0;
      echo_byte <= 8'h00;
      xoff_held <= 1'b0;
      RADIO_DATA <= 8'h00;
      RADIO_VALID <= 1'b0;
    end else begin
      RADIO_VALID <= 1'b0;
      if (rx_done) begin
        echo_byte <= rx_char;
        if (!hw_fc && rx_char == `CHAR_XOFF) begin
          xoff_held <= 1'b1;
        end else if (!hw_fc && rx_char == `CHAR_XON) begin
          xoff_held <= 1'b0;
        end else if (!(flags[`BIT_WRAP] && (rx_char == `CHAR_STX || rx_char == `CHAR_ETX))) begin
          // Wrapper characters are framing only and never forwarded
          rx_data <= rx_char;
          rx_avail <= 1'b1;
          RADIO_DATA <= rx_char;
          RADIO_VALID <= 1'b1;
        end
      end else if (rd_en && PADDR == `ADDR_RX_DATA) begin
        rx_avail <= 1'b0;
      end
      if (hw_fc) begin
        xoff_held <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // APB read and answer
  // ----------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
      if (PSEL && !PENABLE) begin
        case (PADDR)
          `ADDR_LINE_CONFIG: PRDATA <= {16'h0000, uart_line_config};
          `ADDR_PIN_CTRL_A: PRDATA <= {24'h000000, pin_control_reg_a};
          `ADDR_PIN_CTRL_B: PRDATA <= {24'h000000, pin_control_reg_b};
          `ADDR_STATUS: PRDATA <= {19'h00000, fill, drop_seen, rx_par_err,
            xoff_held, rx_avail};
          `ADDR_RX_DATA: PRDATA <= {24'h000000, rx_data};
          `ADDR_TX_DATA: PRDATA <= 32'h00000000;
          default: PSLVERR <= 1'b1;
        endcase
      end
    end
  end
  logic unused_half;
  assign unused_half = ^half_bit;
endmodule

// ### uart_cfg_monitor.sv
// Port checker for the host serial configuration block
`timescale 1ns/10ps
module uart_cfg_monitor #(
  parameter int TX_DEPTH = 128
) (
  // System
  input wire logic CLK_SYS,
  input wire logic RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Line
  input wire logic TXD,
  input wire logic RADIO_VALID
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // ----------
  // Assertions
  // ----------
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_rdata_quiet: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside ready");
  a_cfg_reserved_zero: assert property (PREADY && !PWRITE && PADDR == 12'h000
    |-> PRDATA[31:16] == 16'h0 && !PRDATA[6])
    else $error("config readback has reserved bits");
  a_err_unmapped: assert property (PSEL && !PENABLE && PADDR > 12'h014 |=> PSLVERR)
    else $error("unmapped access not refused");
  // Fastest rate still gives far more than eight cycles per bit
  a_start_bit_held: assert property ($fell(TXD) |=> !TXD [*8])
    else $error("start bit too short");
  a_radio_pulse: assert property (RADIO_VALID |=> !RADIO_VALID)
    else $error("radio strobe not a pulse");
endmodule

bind host_uart_line_config uart_cfg_monitor #(.TX_DEPTH(TX_DEPTH)) mon (
  .CLK_SYS(CLK_SYS),
  .RST(RST),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PRDATA(PRDATA),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .TXD(TXD),
  .RADIO_VALID(RADIO_VALID)
);

// ### host_serial.sv
// Serial host model driving the receive line
`timescale 1ns/10ps
module host_serial (
  // System
  input wire logic clk,
  // Line
  output logic rxd,
  output logic cts_n
);
  // Line idles at mark; host always willing to take data
  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end
  // ----------
  // Framing
  // ----------
  // Bits after the start bit, LSB first; unused tail reads as stop level
  function automatic logic [11:0] frame(input logic [7:0] d, input int nb, input int par,
                                        input int ns);
    logic [11:0] v;
    v = 12'hfff;
    for (int i = 0; i < nb; i++) v[i] = d[i];
    if (par != 0) v[nb] = (^(d & ((nb == 7) ? 8'h7f : 8'hff))) ^ (par == 2);
    return v;
  endfunction
  task automatic send(input logic [7:0] d, input int nb, input int par, input int ns,
                      input int bt);
    logic [11:0] v;
    v = frame(d, nb, par, ns);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (bt) @(posedge clk);
    for (int i = 0; i < nb + (par != 0) + ns; i++) begin
      rxd <= v[i];
      repeat (bt) @(posedge clk);
    end
  endtask
endmodule

// ### testbench.sv
// Testbench for the host serial configuration block
`timescale 1ns/10ps
`include "uart_cfg_consts.svh"
module testbench;
  localparam int BT = `CLK_HZ / 115200;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA, r;
  logic PREADY, PSLVERR, TXD, RXD, RADIO_VALID, cts_n, e, s;
  logic [7:0] GP_OUT, GP_OE, RADIO_DATA, radio_last, f;
  logic [7:0] flg [3] = '{8'h0d, 8'h03, 8'h00};
  logic [11:0] v;
  int num_errors = 0, checked = 0, radio_cnt = 0, nb, par, ns;
  always #5 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) if (RADIO_VALID === 1'b1) begin
    radio_cnt++;
    radio_last = RADIO_DATA;
  end
  host_uart_line_config DUT (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TXD(TXD), .RXD(RXD), .GP_OUT(GP_OUT), .GP_OE(GP_OE),
    .GP_IN({1'b0, 3'h5, 1'b1, cts_n, 2'h2}), .RADIO_DATA(RADIO_DATA),
    .RADIO_VALID(RADIO_VALID));
  host_serial hst (.clk(CLK_SYS), .rxd(RXD), .cts_n(cts_n));
  // ----------
  // Tasks
  // ----------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 1, 0);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Samples each bit at its middle; seen stays low if no start bit comes
  task automatic grab(input int len, output logic [11:0] q, output logic seen);
    int n;
    n = 0;
    q = 12'hfff;
    seen = 1'b0;
    while (TXD !== 1'b0 && n < 14 * BT) begin
      @(posedge CLK_SYS);
      n++;
    end
    if (TXD === 1'b0) begin
      seen = 1'b1;
      repeat (BT / 2) @(posedge CLK_SYS);
      for (int i = 0; i < len; i++) begin
        repeat (BT) @(posedge CLK_SYS);
        q[i] = TXD;
      end
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------
  // Tests
  // ----------
  initial begin
    repeat (20) @(posedge CLK_SYS);
    RST <= 1'b0;
    apb(0, `ADDR_LINE_CONFIG, 0);
    chk("cfg reset", 32'h0500, r);
    apb(0, 12'h040, 0);
    chk("unmapped", 1, e);
    apb(1, `ADDR_LINE_CONFIG, 32'hffffffff);
    apb(0, `ADDR_LINE_CONFIG, 0);
    chk("cfg bit6", 32'hffbf, r);
    $display("regs done");
    apb(1, `ADDR_PIN_CTRL_A, 32'hff);
    apb(1, `ADDR_PIN_CTRL_B, 32'hff);
    apb(1, `ADDR_LINE_CONFIG, 32'h0c20);
    repeat (3) @(posedge CLK_SYS);
    chk("hw pins", 32'hebfb, {GP_OUT, GP_OE});
    apb(1, `ADDR_PIN_CTRL_B, 32'h0);
    repeat (3) @(posedge CLK_SYS);
    chk("hw block", 32'h10, GP_OE);
    apb(1, `ADDR_LINE_CONFIG, 32'h0c00);
    repeat (3) @(posedge CLK_SYS);
    chk("soft pins", 32'hff, GP_OUT);
    $display("pins done");
    for (int k = 0; k < 3; k++) begin
      f = flg[k];
      nb = f[3] ? 7 : 8;
      par = f[1] ? 2 : (f[0] ? 1 : 0);
      ns = f[2] ? 2 : 1;
      apb(1, `ADDR_LINE_CONFIG, {16'h0, 8'h0c, f | 8'h10});
      apb(1, `ADDR_TX_DATA, 32'ha5);
      grab(nb + (par != 0) + ns, v, s);
      chk("tx frame", hst.frame(8'ha5, nb, par, ns), v);
    end
    $display("tx done");
    apb(1, `ADDR_LINE_CONFIG, 32'h0c01);
    fork
      hst.send(8'h96, 8, 1, 1, BT);
      grab(10, v, s);
    join
    chk("echo", hst.frame(8'h96, 8, 1, 1), v);
    chk("radio", 32'h96, radio_last);
    apb(0, `ADDR_RX_DATA, 0);
    chk("rx data", 32'h96, r);
    apb(1, `ADDR_LINE_CONFIG, 32'h0c12);
    fork
      hst.send(8'h96, 8, 2, 1, BT);
      grab(10, v, s);
    join
    chk("no echo", 0, s);
    chk("radio count", 2, radio_cnt);
    // XOFF sent with even parity while odd is set: pause and parity error both
    hst.send(`CHAR_XOFF, 8, 1, 1, BT);
    apb(0, `ADDR_STATUS, 0);
    chk("xoff parity", 32'h6, r & 32'h6);
    apb(1, `ADDR_LINE_CONFIG, 32'h0c90);
    hst.send(`CHAR_STX, 8, 0, 1, BT);
    repeat (BT) @(posedge CLK_SYS);
    chk("wrap strip", 2, radio_cnt);
    $display("rx done");
    // Line is paused by XOFF, so nothing drains and the queue overflows
    for (int k = 0; k < 130; k++) apb(1, `ADDR_TX_DATA, k);
    apb(0, `ADDR_STATUS, 0);
    chk("drop", 32'h8, r & 32'h8);
    chk("xoff pause", 32'h800, r & 32'h1ff0);
    RST <= 1'b1;
    repeat (20) @(posedge CLK_SYS);
    RST <= 1'b0;
    apb(0, `ADDR_LINE_CONFIG, 0);
    chk("cfg re-reset", 32'h0500, r);
    $display("drop done");
    tally_and_finish();
  end
  initial begin
    repeat (95000) @(posedge CLK_SYS);
    chk("watchdog", 1, 0);
    tally_and_finish();
  end
endmodule
